// >>> hw/bridge_regs_pkg.sv
// Constants for the bridge system error and secondary clock configuration registers
// How it works
// [RULE_01] Event mask resets to 00h, so every cause reports by default.
// [RULE_02] Mask bit 6 clear: delayed read retry timeout raises system error.
// [RULE_03] Mask bit 5 clear: delayed write retry timeout raises system error.
// [RULE_04] Mask bit 2 clear: posted write retry timeout raises system error.
// [RULE_05] Mask bit 4 clear: posted write master abort raises system error; set suppresses.
// [RULE_06] Mask bit 3 clear: posted write target abort raises system error; set suppresses.
// [RULE_07] Mask bit 1 clear: posted write parity error raises system error.
// [RULE_08] Bits 7 and 0 of mask and cause ignore writes, read zero.
// [RULE_09] Clock outputs 0-3 stop high only when their two-bit field is 11.
// [RULE_10] Clock gate bit 8 set stops output 4 high; clear keeps it toggling.
// [RULE_11] Clock gate bits 15-9 read zero and ignore writes.
// [RULE_12] Cause bits 6-1 set when system error raised for the matching cause.
// [RULE_13] Writing 1 clears a cause bit; writing 0 leaves it.
// [RULE_14] Capability identifier byte always reads 01h.
// [RULE_15] Next capability byte reads E4h in hot-swap compact mode, else 00h.
// [RULE_16] Masked cause leaves its status bit unchanged.
// [RULE_17] Each transaction's retry count restarts at completion or discard.
package bridge_regs_pkg;

  // Byte offsets
  localparam logic [7:0]  ADDR_EVENT_MASK   = 8'h64;
  localparam logic [7:0]  ADDR_CLK_GATE_LO  = 8'h68;
  localparam logic [7:0]  ADDR_CLK_GATE_HI  = 8'h69;
  localparam logic [7:0]  ADDR_CAUSE        = 8'h6A;
  localparam logic [7:0]  ADDR_CAP_ID       = 8'hDC;
  localparam logic [7:0]  ADDR_NEXT_CAP     = 8'hDD;

  // Reset values and writable bits
  localparam logic [7:0]  EVENT_MASK_RESET  = 8'h00;
  localparam logic [7:0]  CAUSE_RESET       = 8'h00;
  localparam logic [15:0] CLK_GATE_RESET    = 16'h0000;
  localparam logic [7:0]  EVENT_BITS        = 8'h7E;
  localparam logic [7:0]  CLK_GATE_HI_BITS  = 8'h01;

  // Cause bit positions
  localparam int          BIT_DR_TIMEOUT    = 6;
  localparam int          BIT_DW_TIMEOUT    = 5;
  localparam int          BIT_PW_MABORT     = 4;
  localparam int          BIT_PW_TABORT     = 3;
  localparam int          BIT_PW_TIMEOUT    = 2;
  localparam int          BIT_PW_PARITY     = 1;

  // Retry counter channels
  localparam int          XACT_COUNT        = 3;
  localparam int          XACT_DR           = 0;
  localparam int          XACT_DW           = 1;
  localparam int          XACT_PW           = 2;
  localparam int unsigned RETRY_LIMIT       = 32'd16777216;

  // Secondary clocks
  localparam int          SEC_CLK_COUNT     = 5;
  localparam int          GATE_FIELD_W      = 2;
  localparam logic [1:0]  GATE_STOP_CODE    = 2'h3;

  // Capability values
  localparam logic [7:0]  CAP_ID_VALUE      = 8'h01;
  localparam logic [7:0]  NEXT_CAP_COMPACT  = 8'hE4;
  localparam logic [7:0]  NEXT_CAP_OTHER    = 8'h00;

endpackage : bridge_regs_pkg

// >>> hw/retry_if.sv
// Carrier between the register block and the retry limit timers
`timescale 1ns/100ps
interface retry_if #(parameter int N = 3);
  logic [N-1:0] retry;
  logic [N-1:0] done;
  logic [N-1:0] timeout;
  modport owner   (output retry, output done, input timeout);
  modport counter (input retry, input done, output timeout);
endinterface : retry_if

// >>> hw/retry_limit_timer.sv
// Per-transaction retry counters that flag a master timeout
`timescale 1ns/100ps
module retry_limit_timer #(
  parameter int          N     = 3,
  parameter int unsigned LIMIT = bridge_regs_pkg::RETRY_LIMIT
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // Retry events and timeout pulses
  retry_if.counter bus
);
  localparam int CW = $clog2(LIMIT + 1);
  localparam logic [CW-1:0] LAST = CW'(LIMIT - 1);

  typedef struct packed {
    logic [N-1:0][CW-1:0] cnt;
    logic [N-1:0]         timeout;
  } timer_t;

  timer_t s_q;
  timer_t s_d;

  always_comb begin
    s_d = s_q;
    for (int i = 0; i < N; i++) begin
      s_d.timeout[i] = 1'b0;
      if (bus.done[i]) begin
        s_d.cnt[i] = '0; // [RULE_17]
      end else if (bus.retry[i]) begin
        if (s_q.cnt[i] == LAST) begin
          s_d.timeout[i] = 1'b1;
          s_d.cnt[i]     = '0; // [RULE_17]
        end else begin
          s_d.cnt[i] = s_q.cnt[i] + CW'(1);
        end
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign bus.timeout = s_q.timeout;

endmodule : retry_limit_timer

// >>> hw/sec_clock_gate.sv
// Secondary clock outputs, each stoppable and then held high
`timescale 1ns/100ps
module sec_clock_gate #(
  parameter int N = 5
) (
  // Clock and reset
  input  wire logic         ref_clk,
  input  wire logic         reset,
  // Stop requests and clock outputs
  input  wire logic [N-1:0] stop,
  output logic      [N-1:0] clk_out
);
  typedef struct packed {
    logic         phase;
    logic [N-1:0] out;
  } gate_t;

  gate_t s_q;
  gate_t s_d;

  always_comb begin
    s_d       = s_q;
    s_d.phase = ~s_q.phase;
    for (int i = 0; i < N; i++) begin
      s_d.out[i] = stop[i] | s_q.phase;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      s_q <= '{phase: 1'b0, out: {N{1'b1}}};
    end else begin
      s_q <= s_d;
    end
  end

  assign clk_out = s_q.out;

endmodule : sec_clock_gate

// >>> hw/bridge_serr_clock_config_regs.sv
// System error reporting, secondary clock gating and capability registers
`timescale 1ns/100ps
module bridge_serr_clock_config_regs #(
  parameter int unsigned RETRY_LIMIT = bridge_regs_pkg::RETRY_LIMIT
) (
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       reset,
  // Register port
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  // Delayed and posted transaction events
  input  wire logic       dr_retry,
  input  wire logic       dr_done,
  input  wire logic       dw_retry,
  input  wire logic       dw_done,
  input  wire logic       pw_retry,
  input  wire logic       pw_done,
  input  wire logic       pw_master_abort,
  input  wire logic       pw_target_abort,
  input  wire logic       pw_parity_error,
  // Mode strap
  input  wire logic       hot_swap_mode_strap,
  // System error and secondary clocks
  output logic            primary_system_error_out,
  output logic            sec_clk_out_0,
  output logic            sec_clk_out_1,
  output logic            sec_clk_out_2,
  output logic            sec_clk_out_3,
  output logic            sec_clk_out_4
);

  typedef struct packed {
    logic [7:0] mask;
    logic [8:0] gate;
    logic [7:0] cause;
    logic       serr;
    logic [7:0] rdata;
    logic       strap_done;
    logic       compact;
  } regs_t;

  localparam regs_t RESET_STATE = '{
    mask:       bridge_regs_pkg::EVENT_MASK_RESET,
    gate:       bridge_regs_pkg::CLK_GATE_RESET[8:0],
    cause:      bridge_regs_pkg::CAUSE_RESET,
    serr:       1'b0,
    rdata:      8'h00,
    strap_done: 1'b0,
    compact:    1'b0
  };

  function automatic logic field_stops(input logic [1:0] code);
    return code == bridge_regs_pkg::GATE_STOP_CODE;
  endfunction : field_stops

  regs_t s_q;
  regs_t s_d;

  // Retry limit timers
  retry_if #(.N(bridge_regs_pkg::XACT_COUNT)) rif ();

  assign rif.retry = {pw_retry, dw_retry, dr_retry};
  assign rif.done  = {pw_done, dw_done, dr_done};

  retry_limit_timer #(
    .N     (bridge_regs_pkg::XACT_COUNT),
    .LIMIT (RETRY_LIMIT)
  ) u_timer (
    .ref_clk (ref_clk),
    .reset   (reset),
    .bus     (rif.counter)
  );

  // Cause events lined up with the cause bit positions
  logic [7:0] events;
  logic [7:0] fire;

  always_comb begin
    events = 8'h00;
    events[bridge_regs_pkg::BIT_DR_TIMEOUT] = rif.timeout[bridge_regs_pkg::XACT_DR];
    events[bridge_regs_pkg::BIT_DW_TIMEOUT] = rif.timeout[bridge_regs_pkg::XACT_DW];
    events[bridge_regs_pkg::BIT_PW_MABORT]  = pw_master_abort;
    events[bridge_regs_pkg::BIT_PW_TABORT]  = pw_target_abort;
    events[bridge_regs_pkg::BIT_PW_TIMEOUT] = rif.timeout[bridge_regs_pkg::XACT_PW];
    events[bridge_regs_pkg::BIT_PW_PARITY]  = pw_parity_error;
  end

  // A set mask bit suppresses its cause
  assign fire = events & ~s_q.mask & bridge_regs_pkg::EVENT_BITS; // [RULE_02] [RULE_03] [RULE_04] [RULE_05] [RULE_06] [RULE_07] [RULE_16]

  // Clock stop decode
  logic [bridge_regs_pkg::SEC_CLK_COUNT-1:0] stop;

  genvar g;
  generate
    for (g = 0; g < bridge_regs_pkg::SEC_CLK_COUNT - 1; g++) begin : g_field
      assign stop[g] = field_stops(s_q.gate[g*2 +: 2]); // [RULE_09]
    end
  endgenerate
  assign stop[bridge_regs_pkg::SEC_CLK_COUNT-1] = s_q.gate[8]; // [RULE_10]

  logic [bridge_regs_pkg::SEC_CLK_COUNT-1:0] clk_vec;

  sec_clock_gate #(
    .N (bridge_regs_pkg::SEC_CLK_COUNT)
  ) u_clk (
    .ref_clk (ref_clk),
    .reset   (reset),
    .stop    (stop),
    .clk_out (clk_vec)
  );

  always_comb begin
    s_d       = s_q;
    s_d.rdata = 8'h00;
    s_d.serr  = |fire; // [RULE_02] [RULE_03] [RULE_04] [RULE_05] [RULE_06] [RULE_07]

    // Strap caught once after reset release
    if (!s_q.strap_done) begin
      s_d.strap_done = 1'b1;
      s_d.compact    = hot_swap_mode_strap;
    end

    if (reg_wr) begin
      case (reg_addr)
        bridge_regs_pkg::ADDR_EVENT_MASK: begin
          s_d.mask = reg_wdata & bridge_regs_pkg::EVENT_BITS; // [RULE_08]
        end
        bridge_regs_pkg::ADDR_CLK_GATE_LO: begin
          s_d.gate[7:0] = reg_wdata;
        end
        bridge_regs_pkg::ADDR_CLK_GATE_HI: begin
          s_d.gate[8] = reg_wdata[0]; // [RULE_11]
        end
        bridge_regs_pkg::ADDR_CAUSE: begin
          s_d.cause = s_q.cause & ~(reg_wdata & bridge_regs_pkg::EVENT_BITS); // [RULE_13]
        end
        default: begin
        end
      endcase
    end

    // Set wins over a clear in the same cycle
    s_d.cause = s_d.cause | fire; // [RULE_12] [RULE_16]

    if (reg_rd) begin
      case (reg_addr)
        bridge_regs_pkg::ADDR_EVENT_MASK:  s_d.rdata = s_q.mask & bridge_regs_pkg::EVENT_BITS; // [RULE_08]
        bridge_regs_pkg::ADDR_CLK_GATE_LO: s_d.rdata = s_q.gate[7:0];
        bridge_regs_pkg::ADDR_CLK_GATE_HI: s_d.rdata = {7'h00, s_q.gate[8]}; // [RULE_11]
        bridge_regs_pkg::ADDR_CAUSE:       s_d.rdata = s_q.cause & bridge_regs_pkg::EVENT_BITS; // [RULE_08]
        bridge_regs_pkg::ADDR_CAP_ID:      s_d.rdata = bridge_regs_pkg::CAP_ID_VALUE; // [RULE_14]
        bridge_regs_pkg::ADDR_NEXT_CAP: begin
          s_d.rdata = s_q.compact ? bridge_regs_pkg::NEXT_CAP_COMPACT : bridge_regs_pkg::NEXT_CAP_OTHER; // [RULE_15]
        end
        default:                           s_d.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      s_q <= RESET_STATE; // [RULE_01]
    end else begin
      s_q <= s_d;
    end
  end

  assign reg_rdata                = s_q.rdata;
  assign primary_system_error_out = s_q.serr;
  assign sec_clk_out_0            = clk_vec[0];
  assign sec_clk_out_1            = clk_vec[1];
  assign sec_clk_out_2            = clk_vec[2];
  assign sec_clk_out_3            = clk_vec[3];
  assign sec_clk_out_4            = clk_vec[4];

  // Checks
  property p_mask_reset;
    @(posedge ref_clk) disable iff (reset)
    $past(reset) |-> (s_q.mask == 8'h00) && (s_q.cause == 8'h00);
  endproperty
  a_mask_reset: assert property (p_mask_reset) else $error("mask or cause not zero after reset"); // [RULE_01]

  property p_dr_report;
    @(posedge ref_clk) disable iff (reset)
    (rif.timeout[0] && !s_q.mask[6]) |=> primary_system_error_out && s_q.cause[6];
  endproperty
  a_dr_report: assert property (p_dr_report) else $error("delayed read timeout not reported"); // [RULE_02]

  property p_dw_report;
    @(posedge ref_clk) disable iff (reset)
    (rif.timeout[1] && !s_q.mask[5]) |=> primary_system_error_out && s_q.cause[5];
  endproperty
  a_dw_report: assert property (p_dw_report) else $error("delayed write timeout not reported"); // [RULE_03]

  property p_pw_timeout_report;
    @(posedge ref_clk) disable iff (reset)
    (rif.timeout[2] && !s_q.mask[2]) |=> primary_system_error_out && s_q.cause[2];
  endproperty
  a_pw_timeout_report: assert property (p_pw_timeout_report) else $error("posted write timeout not reported"); // [RULE_04]

  property p_mabort_report;
    @(posedge ref_clk) disable iff (reset)
    (pw_master_abort && !s_q.mask[4]) |=> primary_system_error_out && s_q.cause[4];
  endproperty
  a_mabort_report: assert property (p_mabort_report) else $error("master abort not reported"); // [RULE_05]

  property p_tabort_masked;
    @(posedge ref_clk) disable iff (reset)
    (s_q.mask[3] && !s_q.cause[3]) |=> !s_q.cause[3];
  endproperty
  a_tabort_masked: assert property (p_tabort_masked) else $error("masked target abort set its cause"); // [RULE_06]

  property p_parity_silent;
    @(posedge ref_clk) disable iff (reset)
    (s_q.mask == 8'h7E) |=> !primary_system_error_out;
  endproperty
  a_parity_silent: assert property (p_parity_silent) else $error("error raised while all causes masked"); // [RULE_07]

  property p_reserved_zero;
    @(posedge ref_clk) disable iff (reset)
    (reg_rd && (reg_addr == 8'h64 || reg_addr == 8'h6A)) |=> (reg_rdata[7] == 1'b0) && (reg_rdata[0] == 1'b0);
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit read as one"); // [RULE_08]

  property p_cause_clear;
    @(posedge ref_clk) disable iff (reset)
    (reg_wr && reg_addr == 8'h6A && fire == 8'h00) |=> s_q.cause == ($past(s_q.cause) & ~$past(reg_wdata) & 8'h7E);
  endproperty
  a_cause_clear: assert property (p_cause_clear) else $error("cause clear wrong"); // [RULE_13]

  property p_clk4_stop;
    @(posedge ref_clk) disable iff (reset)
    s_q.gate[8] |=> sec_clk_out_4;
  endproperty
  a_clk4_stop: assert property (p_clk4_stop) else $error("stopped clock 4 not high"); // [RULE_10]

  property p_cap_id;
    @(posedge ref_clk) disable iff (reset)
    (reg_rd && reg_addr == 8'hDC) |=> reg_rdata == 8'h01;
  endproperty
  a_cap_id: assert property (p_cap_id) else $error("power_capability_identifier wrong"); // [RULE_14]

  property p_tabort_report;
    @(posedge ref_clk) disable iff (reset)
    (pw_target_abort && !s_q.mask[3]) |=> primary_system_error_out && s_q.cause[3];
  endproperty
  a_tabort_report: assert property (p_tabort_report) else $error("target abort not reported"); // [RULE_06]

  property p_parity_report;
    @(posedge ref_clk) disable iff (reset)
    (pw_parity_error && !s_q.mask[1]) |=> primary_system_error_out && s_q.cause[1];
  endproperty
  a_parity_report: assert property (p_parity_report) else $error("parity error not reported"); // [RULE_07]

  property p_masked_hold;
    @(posedge ref_clk) disable iff (reset)
    !$past(reset) |-> (s_q.cause & ~$past(s_q.cause) & $past(s_q.mask)) == 8'h00;
  endproperty
  a_masked_hold: assert property (p_masked_hold) else $error("masked cause set its bit"); // [RULE_16]

  property p_cause_event;
    @(posedge ref_clk) disable iff (reset)
    !$past(reset) |-> (s_q.cause & ~$past(s_q.cause) & ~$past(events)) == 8'h00;
  endproperty
  a_cause_event: assert property (p_cause_event) else $error("cause set with no event"); // [RULE_12]

  property primary_system_error_out_event;
    @(posedge ref_clk) disable iff (reset)
    primary_system_error_out |-> (|($past(events) & ~$past(s_q.mask)));
  endproperty
  a_serr_event: assert property (primary_system_error_out_event) else $error("error raised with no unmasked event"); // [RULE_16]

  property p_reserved_state;
    @(posedge ref_clk) disable iff (reset)
    ((s_q.mask | s_q.cause) & 8'h81) == 8'h00;
  endproperty
  a_reserved_state: assert property (p_reserved_state) else $error("reserved bit stored"); // [RULE_08]

  property p_mask_write;
    @(posedge ref_clk) disable iff (reset)
    (reg_wr && reg_addr == 8'h64) |=> s_q.mask == ($past(reg_wdata) & 8'h7E);
  endproperty
  a_mask_write: assert property (p_mask_write) else $error("mask write wrong"); // [RULE_08]

  property p_gate_write;
    @(posedge ref_clk) disable iff (reset)
    (reg_wr && reg_addr == 8'h68) |=> s_q.gate[7:0] == $past(reg_wdata);
  endproperty
  a_gate_write: assert property (p_gate_write) else $error("clock gate low write wrong"); // [RULE_09]

  property p_gate_hi_write;
    @(posedge ref_clk) disable iff (reset)
    (reg_wr && reg_addr == 8'h69) |=> s_q.gate[8] == $past(reg_wdata[0]);
  endproperty
  a_gate_hi_write: assert property (p_gate_hi_write) else $error("clock gate bit 8 write wrong"); // [RULE_10]

  property p_gate_hi_read;
    @(posedge ref_clk) disable iff (reset)
    (reg_rd && reg_addr == 8'h69) |=> reg_rdata[7:1] == 7'h00;
  endproperty
  a_gate_hi_read: assert property (p_gate_hi_read) else $error("clock gate reserved bit read as one"); // [RULE_11]

  property p_clk0_stop;
    @(posedge ref_clk) disable iff (reset)
    (s_q.gate[1:0] == 2'h3) |=> sec_clk_out_0;
  endproperty
  a_clk0_stop: assert property (p_clk0_stop) else $error("stopped clock 0 not high"); // [RULE_09]

  property p_clk3_stop;
    @(posedge ref_clk) disable iff (reset)
    (s_q.gate[7:6] == 2'h3) |=> sec_clk_out_3;
  endproperty
  a_clk3_stop: assert property (p_clk3_stop) else $error("stopped clock 3 not high"); // [RULE_09]

  property p_clk1_run;
    @(posedge ref_clk) disable iff (reset)
    (s_q.gate[3:2] != 2'h3) ##1 (s_q.gate[3:2] != 2'h3) |=> sec_clk_out_1 != $past(sec_clk_out_1);
  endproperty
  a_clk1_run: assert property (p_clk1_run) else $error("running clock 1 not toggling"); // [RULE_09]

  property p_next_cap;
    @(posedge ref_clk) disable iff (reset)
    (reg_rd && reg_addr == 8'hDD) |=> reg_rdata == (s_q.compact ? 8'hE4 : 8'h00);
  endproperty
  a_next_cap: assert property (p_next_cap) else $error("next capability wrong"); // [RULE_15]

  property p_retry_restart;
    @(posedge ref_clk) disable iff (reset)
    (|rif.done) |=> (rif.timeout & $past(rif.done)) == 3'h0;
  endproperty
  a_retry_restart: assert property (p_retry_restart) else $error("timeout after transaction done"); // [RULE_17]

  property p_set_wins;
    @(posedge ref_clk) disable iff (reset)
    (reg_wr && reg_addr == 8'h6A && fire != 8'h00) |=> (s_q.cause & $past(fire)) == $past(fire);
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("clear beat a same-cycle cause"); // [RULE_12]

  c_serr:  cover property (@(posedge ref_clk) disable iff (reset) primary_system_error_out);
  c_clear: cover property (@(posedge ref_clk) disable iff (reset) s_q.cause[4] ##1 !s_q.cause[4]);
  c_stop:  cover property (@(posedge ref_clk) disable iff (reset) stop[0] ##2 sec_clk_out_0 [*3]);
  c_race:  cover property (@(posedge ref_clk) disable iff (reset) reg_wr && reg_addr == 8'h6A && fire != 8'h00);
  c_cpct:  cover property (@(posedge ref_clk) disable iff (reset) reg_rd && reg_addr == 8'hDD && s_q.compact);

endmodule : bridge_serr_clock_config_regs

// >>> testbench/config_host_model.sv
// Host model that masters cycles on the register port
`timescale 1ns/100ps
module config_host_model (
  // Clock
  input  wire logic       ref_clk,
  // Register port
  output logic      [7:0] reg_addr,
  output logic      [7:0] reg_wdata,
  output logic            reg_wr,
  output logic            reg_rd,
  input  wire logic [7:0] reg_rdata
);
  initial begin
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
  end

  // One strobe cycle; idle address and data are scrambled afterwards
  task automatic strobe(input logic [7:0] addr, input logic [7:0] data, input logic rd);
    @(posedge ref_clk);
    reg_addr  <= addr;
    reg_wdata <= data;
    reg_wr    <= ~rd;
    reg_rd    <= rd;
    @(posedge ref_clk);
    reg_wr    <= 1'b0;
    reg_rd    <= 1'b0;
    reg_addr  <= ~addr;
    reg_wdata <= ~data;
  endtask : strobe

  task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
    strobe(addr, data, 1'b0);
  endtask : write_reg

  // Read data stand only in the cycle after the strobe
  task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
    strobe(addr, 8'h00, 1'b1);
    #1;
    data = reg_rdata;
  endtask : read_reg
endmodule : config_host_model

// >>> testbench/test_bridge_serr_clock_config_regs.sv
// Self-checking bench for the system error, clock gate and capability registers
`timescale 1ns/100ps
module test_bridge_serr_clock_config_regs;
  localparam int LIMIT = 4;
  typedef struct {logic [7:0] addr; logic [7:0] wdata; logic [7:0] exp;} row_t;
  typedef struct {logic [7:0] lo; logic [7:0] hi; logic [4:0] stop;} gate_t;

  logic       ref_clk;
  logic       reset;
  logic       strap;
  logic [6:1] ev;
  logic [2:0] done;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic       reg_wr;
  logic       reg_rd;
  logic [7:0] reg_rdata;
  logic       serr;
  logic [4:0] sclk;
  logic [7:0] d;
  int         n;
  int         mismatches;
  int         n_tests;
  int         cycles = 0;
  row_t       rows[10];
  gate_t      gates[6];
  int         chb[3] = '{6, 5, 2};

  initial ref_clk = 1'b0;
  always #4 ref_clk = ~ref_clk;

  config_host_model config_host_model_inst (
    .ref_clk(ref_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

  bridge_serr_clock_config_regs #(.RETRY_LIMIT(LIMIT)) bridge_serr_clock_config_regs_inst (
    .ref_clk(ref_clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .dr_retry(ev[6]), .dr_done(done[0]), .dw_retry(ev[5]), .dw_done(done[1]),
    .pw_retry(ev[2]), .pw_done(done[2]), .pw_master_abort(ev[4]),
    .pw_target_abort(ev[3]), .pw_parity_error(ev[1]), .hot_swap_mode_strap(strap),
    .primary_system_error_out(serr), .sec_clk_out_0(sclk[0]), .sec_clk_out_1(sclk[1]),
    .sec_clk_out_2(sclk[2]), .sec_clk_out_3(sclk[3]), .sec_clk_out_4(sclk[4]));

  task automatic final_report;
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : final_report

  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    config_host_model_inst.write_reg(a, v);
  endtask : wr

  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    config_host_model_inst.read_reg(a, d);
    check($sformatf("reg_%h", a), e, d);
  endtask : rchk

  // Hold one cause for n cycles, then count system error pulses and note the first one
  task automatic fire(input int b, input int len, input int lat, input logic masked);
    int first;
    int cnt;
    first = 0;
    cnt   = 0;
    @(posedge ref_clk);
    ev[b] <= 1'b1;
    repeat (len) @(posedge ref_clk);
    ev[b] <= 1'b0;
    for (int j = 1; j <= 8; j++) begin
      #1;
      if (serr !== 1'b0) begin
        cnt++;
        if (first == 0) first = j;
      end
      @(posedge ref_clk);
    end
    check("serr_count", masked ? 8'h00 : 8'h01, 8'(cnt));
    check("serr_latency", masked ? 8'h00 : 8'(lat), 8'(first));
  endtask : fire

  // Stopped outputs sit high, running ones flip every cycle
  task automatic gate_check(input logic [4:0] stop);
    logic [4:0] prev;
    logic [4:0] high;
    logic [4:0] tog;
    repeat (2) @(posedge ref_clk);
    #1;
    prev = sclk;
    high = sclk;
    tog  = 5'h1F;
    repeat (4) begin
      @(posedge ref_clk);
      #1;
      high = high & sclk;
      tog  = tog & (sclk ^ prev);
      prev = sclk;
    end
    check("clk_stopped", {3'h0, stop}, {3'h0, high});
    check("clk_running", {3'h0, ~stop}, {3'h0, tog});
  endtask : gate_check

  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      mismatches++;
      final_report();
    end
  end

  initial begin
    reset = 1'b1;
    strap = 1'b1;
    ev    = '0;
    done  = '0;
    rows  = '{'{8'h64, 8'hFF, 8'h7E}, '{8'h64, 8'h81, 8'h00}, '{8'h68, 8'hA5, 8'hA5},
              '{8'h69, 8'hFF, 8'h01}, '{8'h69, 8'h00, 8'h00}, '{8'h68, 8'h00, 8'h00},
              '{8'hDC, 8'hFF, 8'h01}, '{8'hDD, 8'h00, 8'hE4}, '{8'h6A, 8'hFF, 8'h00},
              '{8'h65, 8'hFF, 8'h00}};
    gates = '{'{8'h00, 8'h00, 5'h00}, '{8'h55, 8'h00, 5'h00}, '{8'hAA, 8'h00, 5'h00},
              '{8'hFF, 8'h01, 5'h1F}, '{8'hE4, 8'h00, 5'h08}, '{8'h1B, 8'h01, 5'h11}};
    repeat (3) @(posedge ref_clk);
    #1;
    check("clk_in_reset", 8'h1F, {3'h0, sclk});
    check("serr_in_reset", 8'h00, {7'h0, serr});
    repeat (9) @(posedge ref_clk);
    reset <= 1'b0;
    rchk(8'h64, 8'h00);
    rchk(8'h68, 8'h00);
    rchk(8'h69, 8'h00);
    rchk(8'h6A, 8'h00);
    rchk(8'hDD, 8'hE4);
    @(posedge ref_clk);
    #1;
    check("rdata_idle", 8'h00, reg_rdata);
    foreach (rows[i]) begin
      wr(rows[i].addr, rows[i].wdata);
      rchk(rows[i].addr, rows[i].exp);
    end
    foreach (gates[i]) begin
      wr(8'h68, gates[i].lo);
      wr(8'h69, gates[i].hi);
      gate_check(gates[i].stop);
    end
    for (int b = 1; b <= 6; b++) begin
      n = (b == 2 || b >= 5) ? LIMIT : 1;
      fire(b, n, (n == 1) ? 1 : 2, 1'b0);
      rchk(8'h6A, 8'h01 << b);
      wr(8'h6A, ~(8'h01 << b));
      rchk(8'h6A, 8'h01 << b);
      wr(8'h6A, 8'h01 << b);
      rchk(8'h6A, 8'h00);
      wr(8'h64, 8'h01 << b);
      fire(b, n, 0, 1'b1);
      rchk(8'h6A, 8'h00);
      wr(8'h64, 8'h00);
    end
    foreach (chb[c]) begin
      fire(chb[c], LIMIT - 1, 0, 1'b1);
      @(posedge ref_clk);
      done[c] <= 1'b1;
      @(posedge ref_clk);
      done[c] <= 1'b0;
      fire(chb[c], LIMIT - 1, 0, 1'b1);
      fire(chb[c], 1, 2, 1'b0);
    end
    rchk(8'h6A, 8'h64);
    fork // Set beats a same-cycle clear
      wr(8'h6A, 8'h02);
      begin
        @(posedge ref_clk);
        ev[1] <= 1'b1;
        @(posedge ref_clk);
        ev[1] <= 1'b0;
      end
    join
    rchk(8'h6A, 8'h66);
    wr(8'h64, 8'hFF);
    @(posedge ref_clk);
    reset <= 1'b1;
    strap <= 1'b0;
    repeat (12) @(posedge ref_clk);
    reset <= 1'b0;
    rchk(8'h64, 8'h00);
    rchk(8'h6A, 8'h00);
    rchk(8'hDD, 8'h00);
    final_report();
  end
endmodule : test_bridge_serr_clock_config_regs
